// [rtl/gdt_pkg.sv]
// Constants, register map and state types of the gated down-counter timer.
// Assumes one 125 MHz clock and a classic Wishbone slave port with byte addresses.
package gdt_pkg;

	localparam int          NUM_CH    = 3;
	localparam int          CNT_W     = 24;
	localparam int          ADR_W     = 8;
	localparam int          CH_STRIDE = 16;
	localparam int          PRE_W     = 16;
	localparam int          SDIV_W    = 17;

	localparam logic [ADR_W-1:0] CH_CTRL_OFS   = 8'h00;
	localparam logic [ADR_W-1:0] CH_RELOAD_OFS = 8'h04;
	localparam logic [ADR_W-1:0] CH_COUNT_OFS  = 8'h08;
	localparam logic [ADR_W-1:0] INT_STAT_OFS  = 8'h30;
	localparam logic [ADR_W-1:0] INT_MASK_OFS  = 8'h34;
	localparam logic [ADR_W-1:0] PRESCALE_OFS  = 8'h38;
	localparam logic [ADR_W-1:0] SAMPLE_DIV_OFS = 8'h3c;

	localparam int          CTL_MODE_LSB  = 0;
	localparam int          CTL_CLK_SEL   = 3;
	localparam int          CTL_GATE_SEL  = 4;
	localparam int          CTL_SW_GATE   = 5;
	localparam int          CNT_OUT_BIT   = 24;
	localparam int          CNT_RUN_BIT   = 25;

	localparam logic [2:0]        MODE_ONE_SHOT = 3'h1;
	localparam logic [2:0]        MODE_RATE     = 3'h2;
	localparam logic [2:0]        MODE_SQUARE   = 3'h3;
	localparam logic [2:0]        MODE_STROBE   = 3'h5;
	localparam logic [CNT_W-1:0]  CNT_ONE       = 24'h000001;
	localparam logic [PRE_W-1:0]  PRE_RESET     = 16'h0000;
	localparam logic [SDIV_W-1:0] SDIV_MIN      = 17'h00028;
	localparam logic [SDIV_W-1:0] SDIV_MAX      = 17'h10000;

	typedef enum logic [1:0] {
		CH_IDLE = 2'b01,
		CH_RUN  = 2'b10
	} gdt_run_t;

	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [ADR_W-1:0] adr;
		logic [3:0]       sel;
		logic [31:0]      dat;
	} gdt_wb_req_t;

	typedef struct packed {
		logic [2:0]       mode;
		logic             clk_sel;
		logic             gate_sel;
		logic             sw_gate;
		logic [CNT_W-1:0] reload;
		logic [CNT_W-1:0] count;
		logic             out;
		gdt_run_t         run;
		logic             clk_s1;
		logic             clk_s2;
		logic             clk_d;
		logic             gate_s1;
		logic             gate_s2;
		logic             gate_prev;
	} gdt_chan_t;

	typedef struct packed {
		gdt_chan_t [NUM_CH-1:0] ch;
		logic [NUM_CH-1:0]      status;
		logic [NUM_CH-1:0]      mask;
		logic                   irq;
		logic [PRE_W-1:0]       prescale;
		logic [PRE_W-1:0]       pre_cnt;
		logic [SDIV_W-1:0]      sample_div;
		logic [SDIV_W-1:0]      sample_cnt;
		logic                   sample_tick;
		logic                   ai_clk;
		logic                   ack;
		logic [31:0]            dat;
	} gdt_state_t;

endpackage : gdt_pkg

// [rtl/gdt_timer.sv]
// Gated down-counter timer: three channels, Wishbone registers, one interrupt.
// Assumes clk_i at 125 MHz, synchronous reset and asynchronous counter pins.
// Behaviour
// - Three identical channels, all free for user work; channel two's clock pin also times the converter.
// - One-shot idles high; gate rise drives output low and counts; expiry restores high.
// - Rate mode pulses output low one counter tick at expiry, then reloads and continues.
// - Rate and square modes count only while gate is high; period equals reload.
// - Square mode goes low at half the reload, high at expiry, then reloads.
// - Strobe mode stays high while counting, drops low one tick at expiry.
// - Strobe counting starts on a gate rising edge, not on gate level.
// - Each channel reload value is 24 bits wide.
// - Software picks each channel clock: internal counter tick or its external pin.
// - Software picks each channel gate: a software bit or its external pin.
// - Each output drives its pin and can raise an interrupt.
// - Every channel has its own clock, gate and output pin.
// - Internal counter clock is M times the sample rate, M from 40 to 64k.
// - Channel two external clock also feeds the converter external sample clock.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module gdt_timer (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire gdt_pkg::gdt_wb_req_t     wb_req_i,
	output logic [31:0]                   wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic [gdt_pkg::NUM_CH-1:0] ctr_clk_i,
	input  wire logic [gdt_pkg::NUM_CH-1:0] ctr_gate_i,
	output logic [gdt_pkg::NUM_CH-1:0]    ctr_out_o,
	output logic                          irq_o,
	output logic                          sample_tick_o,
	output logic                          ai_ext_clk_o
);

	gdt_pkg::gdt_state_t          state_reg;
	gdt_pkg::gdt_state_t          state_next;
	logic [gdt_pkg::NUM_CH-1:0]   tick_v;
	logic [gdt_pkg::NUM_CH-1:0]   gate_v;
	logic [gdt_pkg::NUM_CH-1:0]   rise_v;
	logic                         bus_req;
	logic                         bus_wr;
	logic                         int_tick;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~state_reg.ack;
	assign bus_wr  = bus_req & wb_req_i.we;

	always_comb begin
		gdt_pkg::gdt_chan_t c;
		logic [gdt_pkg::NUM_CH-1:0] evt;
		logic [31:0]                rdata;
		logic [31:0]                wval;
		logic [gdt_pkg::ADR_W-1:0]  base;
		c = '0;
		evt = '0;
		rdata = '0;
		wval = '0;
		base = '0;
		tick_v = '0;
		gate_v = '0;
		rise_v = '0;
		state_next = state_reg;
		state_next.ack = 1'b0;
		state_next.sample_tick = 1'b0;
		// sample divider
		// The sample rate is the internal counter tick divided by M.
		int_tick = (state_reg.pre_cnt == state_reg.prescale);
		state_next.pre_cnt = int_tick ? '0 : state_reg.pre_cnt + 1'b1;
		if (int_tick) begin
			if (state_reg.sample_cnt >= state_reg.sample_div - 1'b1) begin
				state_next.sample_cnt = '0;
				state_next.sample_tick = 1'b1;
			end else begin
				state_next.sample_cnt = state_reg.sample_cnt + 1'b1;
			end
		end
		state_next.ai_clk = state_reg.ch[2].clk_s2;
		for (int i = 0; i < gdt_pkg::NUM_CH; i++) begin
			c = state_reg.ch[i];
			c.clk_s1 = ctr_clk_i[i];
			c.clk_s2 = state_reg.ch[i].clk_s1;
			c.clk_d = state_reg.ch[i].clk_s2;
			c.gate_s1 = ctr_gate_i[i];
			c.gate_s2 = state_reg.ch[i].gate_s1;
			tick_v[i] = state_reg.ch[i].clk_sel ? (state_reg.ch[i].clk_s2 & ~state_reg.ch[i].clk_d) : int_tick;
			gate_v[i] = state_reg.ch[i].gate_sel ? state_reg.ch[i].gate_s2 : state_reg.ch[i].sw_gate;
			c.gate_prev = gate_v[i];
			rise_v[i] = gate_v[i] & ~state_reg.ch[i].gate_prev;
			case (state_reg.ch[i].mode)
				gdt_pkg::MODE_ONE_SHOT: begin
					if (rise_v[i]) begin
						c.count = state_reg.ch[i].reload;
						c.out = 1'b0;
						c.run = gdt_pkg::CH_RUN;
					end else if (tick_v[i] && state_reg.ch[i].run == gdt_pkg::CH_RUN) begin
						if (state_reg.ch[i].count <= gdt_pkg::CNT_ONE) begin
							c.out = 1'b1;
							c.run = gdt_pkg::CH_IDLE;
						end else begin
							c.count = state_reg.ch[i].count - gdt_pkg::CNT_ONE;
						end
					end
				end
				gdt_pkg::MODE_RATE: begin
					if (!gate_v[i]) begin
						c.out = 1'b1;
					end else if (tick_v[i]) begin
						if (state_reg.ch[i].count <= gdt_pkg::CNT_ONE) begin
							c.out = 1'b0;
							c.count = state_reg.ch[i].reload;
						end else begin
							c.out = 1'b1;
							c.count = state_reg.ch[i].count - gdt_pkg::CNT_ONE;
						end
					end
				end
				gdt_pkg::MODE_SQUARE: begin
					if (!gate_v[i]) begin
						c.out = 1'b1;
					end else if (tick_v[i]) begin
						if (state_reg.ch[i].count <= gdt_pkg::CNT_ONE) begin
							c.out = 1'b1;
							c.count = state_reg.ch[i].reload;
						end else begin
							c.count = state_reg.ch[i].count - gdt_pkg::CNT_ONE;
							if (c.count == (state_reg.ch[i].reload >> 1)) begin
								c.out = 1'b0;
							end
						end
					end
				end
				gdt_pkg::MODE_STROBE: begin
					if (rise_v[i]) begin
						c.count = state_reg.ch[i].reload;
						c.out = 1'b1;
						c.run = gdt_pkg::CH_RUN;
					end else if (tick_v[i]) begin
						if (!state_reg.ch[i].out) begin
							c.out = 1'b1;
						end
						if (state_reg.ch[i].run == gdt_pkg::CH_RUN) begin
							if (state_reg.ch[i].count <= gdt_pkg::CNT_ONE) begin
								c.out = 1'b0;
								c.run = gdt_pkg::CH_IDLE;
							end else begin
								c.count = state_reg.ch[i].count - gdt_pkg::CNT_ONE;
							end
						end
					end
				end
				default: begin
					c.out = 1'b1;
					c.run = gdt_pkg::CH_IDLE;
				end
			endcase
			state_next.ch[i] = c;
		end
		// Register access; every request is answered in the next cycle, unmapped ones read zero.
		for (int i = 0; i < gdt_pkg::NUM_CH; i++) begin
			base = gdt_pkg::ADR_W'(i * gdt_pkg::CH_STRIDE);
			if (wb_req_i.adr == base + gdt_pkg::CH_CTRL_OFS) begin
				rdata = {26'h0000000, state_reg.ch[i].sw_gate, state_reg.ch[i].gate_sel,
					state_reg.ch[i].clk_sel, state_reg.ch[i].mode};
				if (bus_wr) begin
					wval = merge_bytes(rdata, wb_req_i.dat, wb_req_i.sel);
					state_next.ch[i].mode = wval[gdt_pkg::CTL_MODE_LSB +: 3];
					state_next.ch[i].clk_sel = wval[gdt_pkg::CTL_CLK_SEL];
					state_next.ch[i].gate_sel = wval[gdt_pkg::CTL_GATE_SEL];
					state_next.ch[i].sw_gate = wval[gdt_pkg::CTL_SW_GATE];
					state_next.ch[i].out = 1'b1;
					state_next.ch[i].run = gdt_pkg::CH_IDLE;
					state_next.ch[i].count = state_reg.ch[i].reload;
				end
			end
			if (wb_req_i.adr == base + gdt_pkg::CH_RELOAD_OFS) begin
				rdata = {8'h00, state_reg.ch[i].reload};
				if (bus_wr) begin
					wval = merge_bytes(rdata, wb_req_i.dat, wb_req_i.sel);
					state_next.ch[i].reload = wval[gdt_pkg::CNT_W-1:0];
					state_next.ch[i].count = wval[gdt_pkg::CNT_W-1:0];
				end
			end
			if (wb_req_i.adr == base + gdt_pkg::CH_COUNT_OFS) begin
				rdata = '0;
				rdata[gdt_pkg::CNT_W-1:0] = state_reg.ch[i].count;
				rdata[gdt_pkg::CNT_OUT_BIT] = state_reg.ch[i].out;
				rdata[gdt_pkg::CNT_RUN_BIT] = (state_reg.ch[i].run == gdt_pkg::CH_RUN);
			end
		end
		for (int i = 0; i < gdt_pkg::NUM_CH; i++) begin
			evt[i] = state_reg.ch[i].out & ~state_next.ch[i].out;
		end
		// Set wins over the read-clear so no expiry in the reading cycle is lost.
		state_next.status = state_reg.status | evt;
		if (wb_req_i.adr == gdt_pkg::INT_STAT_OFS) begin
			rdata = {29'h00000000, state_reg.status};
			if (bus_req && !wb_req_i.we) begin
				state_next.status = evt;
			end
		end
		if (wb_req_i.adr == gdt_pkg::INT_MASK_OFS) begin
			rdata = {29'h00000000, state_reg.mask};
			if (bus_wr) begin
				wval = merge_bytes(rdata, wb_req_i.dat, wb_req_i.sel);
				state_next.mask = wval[gdt_pkg::NUM_CH-1:0];
			end
		end
		if (wb_req_i.adr == gdt_pkg::PRESCALE_OFS) begin
			rdata = {16'h0000, state_reg.prescale};
			if (bus_wr) begin
				wval = merge_bytes(rdata, wb_req_i.dat, wb_req_i.sel);
				state_next.prescale = wval[gdt_pkg::PRE_W-1:0];
				state_next.pre_cnt = '0;
			end
		end
		if (wb_req_i.adr == gdt_pkg::SAMPLE_DIV_OFS) begin
			rdata = {15'h0000, state_reg.sample_div};
			if (bus_wr) begin
				wval = merge_bytes(rdata, wb_req_i.dat, wb_req_i.sel);
				if (wval < 32'(gdt_pkg::SDIV_MIN)) begin
					state_next.sample_div = gdt_pkg::SDIV_MIN;
				end else if (wval > 32'(gdt_pkg::SDIV_MAX)) begin
					state_next.sample_div = gdt_pkg::SDIV_MAX;
				end else begin
					state_next.sample_div = wval[gdt_pkg::SDIV_W-1:0];
				end
				state_next.sample_cnt = '0;
			end
		end
		if (bus_req) begin
			state_next.ack = 1'b1;
			state_next.dat = rdata;
		end
		state_next.irq = |(state_next.status & state_next.mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.prescale <= gdt_pkg::PRE_RESET;
			state_reg.sample_div <= gdt_pkg::SDIV_MIN;
			for (int i = 0; i < gdt_pkg::NUM_CH; i++) begin
				state_reg.ch[i].out <= 1'b1;
				state_reg.ch[i].run <= gdt_pkg::CH_IDLE;
			end
		end else begin
			state_reg <= state_next;
		end
	end

	for (genvar g = 0; g < gdt_pkg::NUM_CH; g++) begin : g_out
		assign ctr_out_o[g] = state_reg.ch[g].out;
	end
	assign wb_dat_o      = state_reg.dat;
	assign wb_ack_o      = state_reg.ack;
	assign irq_o         = state_reg.irq;
	assign sample_tick_o = state_reg.sample_tick;
	assign ai_ext_clk_o  = state_reg.ai_clk;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_oneshot_goes_low: assert property (
		state_reg.ch[0].mode == gdt_pkg::MODE_ONE_SHOT && rise_v[0] && !bus_wr
		|=> !ctr_out_o[0] && state_reg.ch[0].run == gdt_pkg::CH_RUN)
		else $error("one-shot output did not fall on gate rise");
	a_rate_pulse_width: assert property (
		state_reg.ch[1].mode == gdt_pkg::MODE_RATE && !ctr_out_o[1] && gate_v[1] && tick_v[1]
		&& state_reg.ch[1].count > gdt_pkg::CNT_ONE && !bus_wr |=> ctr_out_o[1])
		else $error("rate pulse lasted more than one tick");
	a_gate_hold_count: assert property (
		(state_reg.ch[1].mode == gdt_pkg::MODE_RATE || state_reg.ch[1].mode == gdt_pkg::MODE_SQUARE)
		&& !gate_v[1] && !bus_wr |=> $stable(state_reg.ch[1].count))
		else $error("count moved while gate low");
	a_square_half_low: assert property (
		state_reg.ch[2].mode == gdt_pkg::MODE_SQUARE && gate_v[2] && tick_v[2] && !bus_wr
		&& state_reg.ch[2].count - gdt_pkg::CNT_ONE == (state_reg.ch[2].reload >> 1)
		&& state_reg.ch[2].count > gdt_pkg::CNT_ONE |=> !ctr_out_o[2])
		else $error("square wave not low at half count");
	a_strobe_high_run: assert property (
		state_reg.ch[0].mode == gdt_pkg::MODE_STROBE && $rose(state_reg.ch[0].run == gdt_pkg::CH_RUN)
		|-> ctr_out_o[0])
		else $error("strobe output low while counting starts");
	a_strobe_edge_start: assert property (
		state_reg.ch[0].mode == gdt_pkg::MODE_STROBE && gate_v[0] && !rise_v[0]
		&& state_reg.ch[0].run == gdt_pkg::CH_IDLE && !bus_wr |=> state_reg.ch[0].run == gdt_pkg::CH_IDLE)
		else $error("strobe started on gate level");
	a_retrigger_reload: assert property (
		(state_reg.ch[0].mode == gdt_pkg::MODE_ONE_SHOT || state_reg.ch[0].mode == gdt_pkg::MODE_STROBE)
		&& rise_v[0] && !bus_wr |=> state_reg.ch[0].count == $past(state_reg.ch[0].reload))
		else $error("gate rise did not reload the count");
	a_gate_low_high: assert property (
		state_reg.ch[2].mode == gdt_pkg::MODE_SQUARE && !gate_v[2] |=> ctr_out_o[2])
		else $error("output not high while gate low");
	a_irq_follows_mask: assert property (
		$rose(state_reg.status[0]) && state_reg.mask[0] |-> irq_o)
		else $error("unmasked event did not raise interrupt");
	a_sample_div_bound: assert property (
		state_reg.sample_div >= gdt_pkg::SDIV_MIN && state_reg.sample_div <= gdt_pkg::SDIV_MAX
		&& state_reg.sample_cnt < state_reg.sample_div)
		else $error("sample divider out of range");
	a_shared_ext_clk: assert property (
		ai_ext_clk_o == $past(state_reg.ch[2].clk_s2))
		else $error("sample clock does not follow channel two pin");
	a_ack_one_cycle: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held longer than one cycle");

endmodule : gdt_timer

// [dv/gdt_pins_model.sv]
// Pin model for the counter clock and gate pins of all three channels.
// Assumes the bench calls its tasks; each clock pin stands low between bursts.
`timescale 1ns/1ps
module gdt_pins_model (
	input  wire logic  clk_i,
	output logic [2:0] ctr_clk_o,
	output logic [2:0] ctr_gate_o
);
	initial begin
		ctr_clk_o  = 3'h0;
		ctr_gate_o = 3'h0;
	end

	// Four cycles high and four low keeps the pin slower than a quarter of clk_i.
	task automatic ticks(input int ch, input int n);
		repeat (n) begin
			@(posedge clk_i);
			ctr_clk_o[ch] <= 1'b1;
			repeat (4) @(posedge clk_i);
			ctr_clk_o[ch] <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask : ticks

	task automatic set_gate(input int ch, input logic v);
		@(posedge clk_i);
		ctr_gate_o[ch] <= v;
	endtask : set_gate

	// Pulses stay at least three cycles wide so the synchroniser never drops one.
	task automatic gate_pulse(input int ch, input int hi, input int lo);
		@(posedge clk_i);
		ctr_gate_o[ch] <= 1'b1;
		repeat (hi) @(posedge clk_i);
		ctr_gate_o[ch] <= 1'b0;
		repeat (lo) @(posedge clk_i);
		ctr_gate_o[ch] <= 1'b1;
	endtask : gate_pulse
endmodule : gdt_pins_model

// [dv/tb_top.sv]
// Self-checking bench of the gated down-counter timer, one task per scenario.
// Assumes the pin model drives the counter pins and registers sit on Wishbone.
`timescale 1ns/1ps
module tb_top;
	logic                 clk_i = 1'b0;
	logic                 rst_i = 1'b1;
	gdt_pkg::gdt_wb_req_t req   = '0;
	logic [31:0]          wb_dat_o;
	logic                 wb_ack_o;
	logic [2:0]           pin_clk;
	logic [2:0]           pin_gate;
	logic [2:0]           ctr_out_o;
	logic                 irq_o;
	logic                 sample_tick_o;
	logic                 ai_ext_clk_o;
	int                   err_count = 0;
	int                   compares  = 0;
	int                   lows;
	int                   falls;

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	gdt_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ctr_clk_i(pin_clk), .ctr_gate_i(pin_gate), .ctr_out_o(ctr_out_o), .irq_o(irq_o),
		.sample_tick_o(sample_tick_o), .ai_ext_clk_o(ai_ext_clk_o));
	gdt_pins_model pins (.clk_i(clk_i), .ctr_clk_o(pin_clk), .ctr_gate_o(pin_gate));

	task automatic end_sim();
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			$display("[FAIL] %0t %s", $time, msg);
			err_count++;
		end
	endtask : chk

	// The request is held until the edge at which ack is sampled high; data is taken and the request dropped there.
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
		int n;
		n = 0;
		q = '0;
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			chk(32'h0, 32'h1, "bus timeout");
			end_sim();
		end else begin
			q = wb_dat_o;
			req <= '0;
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string msg);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e, msg);
	endtask : rd

	function automatic logic [31:0] ctl(input logic [2:0] m, input logic cs, input logic gs, input logic sw);
		return {26'h0, sw, gs, cs, m};
	endfunction : ctl

	task automatic watch(input int ch, input int n);
		logic prev;
		lows  = 0;
		falls = 0;
		prev  = ctr_out_o[ch];
		repeat (n) begin
			@(posedge clk_i);
			#1;
			if (ctr_out_o[ch] === 1'b0) lows++;
			if (prev === 1'b1 && ctr_out_o[ch] === 1'b0) falls++;
			prev = ctr_out_o[ch];
		end
	endtask : watch

	task automatic t_reset();
		chk(ctr_out_o, 3'h7, "outputs not idle high");
		chk(irq_o, 1'b0, "irq after reset");
		rd(8'h00, 32'h0, "ctrl reset value");
		rd(8'h34, 32'h0, "mask reset value");
		wr(8'h40, 32'hffffffff);
		rd(8'h40, 32'h0, "unmapped read");
	endtask : t_reset

	task automatic t_oneshot_irq();
		wr(8'h04, 32'h3);
		wr(8'h00, ctl(3'h1, 1'b0, 1'b0, 1'b0));
		fork
			wr(8'h00, ctl(3'h1, 1'b0, 1'b0, 1'b1));
			watch(0, 14);
		join
		chk(lows, 3, "one-shot low width");
		chk(falls, 1, "one-shot fall count");
		chk(irq_o, 1'b0, "masked irq raised");
		wr(8'h34, 32'h1);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b1, "unmasked irq missing");
		rd(8'h30, 32'h1, "status after fall");
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0, "irq after status read");
		rd(8'h30, 32'h0, "status not cleared");
	endtask : t_oneshot_irq

	task automatic t_strobe();
		wr(8'h00, ctl(3'h5, 1'b0, 1'b0, 1'b0));
		fork
			wr(8'h00, ctl(3'h5, 1'b0, 1'b0, 1'b1));
			watch(0, 14);
		join
		chk(lows, 1, "strobe low width");
		watch(0, 14);
		chk(falls, 0, "strobe ran on gate level");
	endtask : t_strobe

	task automatic t_square();
		wr(8'h24, 32'h4);
		wr(8'h20, ctl(3'h3, 1'b0, 1'b0, 1'b1));
		watch(2, 8);
		chk(lows, 4, "square duty");
		chk(falls, 2, "square period");
		wr(8'h20, ctl(3'h3, 1'b0, 1'b0, 1'b0));
		watch(2, 8);
		chk(lows, 0, "square ran with gate low");
		rd(8'h28, 32'h01000004, "square count not held");
	endtask : t_square

	task automatic t_rate_pins();
		pins.set_gate(1, 1'b1);
		wr(8'h14, 32'h3);
		wr(8'h10, ctl(3'h2, 1'b1, 1'b1, 1'b0));
		fork
			pins.ticks(1, 10);
			watch(1, 90);
		join
		chk(falls, 3, "rate pulse count");
		chk(lows, 24, "rate pulse width");
		pins.set_gate(1, 1'b0);
		fork
			pins.ticks(1, 6);
			watch(1, 60);
		join
		chk(falls, 0, "rate counted with gate low");
		chk(ctr_out_o[1], 1'b1, "rate output low while held");
		chk(ctr_out_o[0], 1'b1, "channel zero disturbed");
	endtask : t_rate_pins

	task automatic t_retrigger();
		wr(8'h14, 32'h6);
		wr(8'h10, ctl(3'h1, 1'b0, 1'b1, 1'b0));
		fork
			pins.gate_pulse(1, 3, 3);
			watch(1, 26);
		join
		chk(lows, 12, "retrigger low width");
		chk(falls, 1, "retrigger fall count");
		pins.set_gate(1, 1'b0);
	endtask : t_retrigger

	task automatic t_ai_clk();
		int rises;
		logic prev;
		rises = 0;
		prev  = ai_ext_clk_o;
		fork
			pins.ticks(2, 3);
			repeat (32) begin
				@(posedge clk_i);
				#1;
				if (prev === 1'b0 && ai_ext_clk_o === 1'b1) rises++;
				prev = ai_ext_clk_o;
			end
		join
		chk(rises, 3, "converter clock ticks");
	endtask : t_ai_clk

	task automatic period(output int p);
		int n;
		n = 0;
		p = 0;
		while (sample_tick_o !== 1'b1 && n < 100) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		do begin
			@(posedge clk_i);
			#1;
			p++;
		end while (sample_tick_o !== 1'b1 && p < 100);
		if (sample_tick_o !== 1'b1) begin
			chk(32'h0, 32'h1, "sample tick timeout");
			end_sim();
		end
	endtask : period

	task automatic t_sample();
		int p;
		period(p);
		chk(p, 40, "sample period at reset");
		wr(8'h3c, 32'h8);
		rd(8'h3c, 32'h28, "divider not clamped");
		period(p);
		chk(p, 40, "sample period after clamp");
	endtask : t_sample

	task automatic t_width();
		wr(8'h04, 32'hffffffff);
		rd(8'h04, 32'h00ffffff, "reload width");
		rd(8'h08, 32'h01ffffff, "count readback");
	endtask : t_width

	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_oneshot_irq();
		t_strobe();
		t_square();
		t_rate_pins();
		t_retrigger();
		t_ai_clk();
		t_sample();
		t_width();
		end_sim();
	end
endmodule : tb_top
